// ---- logic/sart_timer.sv ----
// Split auto-reload timer: two byte counters, prescalers, capture and register file.
`timescale 1ns/1ps
`default_nettype none
`include "sart_params.svh"
module sart_timer (
	// Clock and reset.
	input  wire logic                    clock_i,
	input  wire logic                    rst_b_i,
	// Register access from the core.
	input  wire sart_pkg::sart_sfr_req_t sfr_req_i,
	output logic [7:0]                   sfr_rdata_o,
	// Clock mode bits held in the shared clock control register.
	input  wire logic                    low_byte_clock_mode_i,
	input  wire logic                    high_byte_clock_mode_i,
	// Slow clock sources, asynchronous to the system clock.
	input  wire logic                    ext_osc_i,
	input  wire logic                    rtc_clk_i,
	// Interrupt enable from the core and request back to it.
	input  wire logic                    irq_enable_i,
	output logic                         irq_o
);

	sart_pkg::sart_state_t state_q;
	sart_pkg::sart_state_t state_d;

	logic ext_rise;
	logic rtc_rise;

	// The divided oscillator edge only enters the counter logic through this stage.
	sart_sync u_ext_sync (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.pin_i   (ext_osc_i),
		.level_o (),
		.rise_o  (ext_rise)
	);

	// The real-time clock gets the same treatment for capture and counting.
	sart_sync u_rtc_sync (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.pin_i   (rtc_clk_i),
		.level_o (),
		.rise_o  (rtc_rise)
	);

	// Prescaler enables, each a single system clock pulse except lo_en and hi_en, which stay high in system clock mode.
	logic tick12;
	logic ext_tick;
	logic rtc_tick;
	logic alt_tick;
	logic lo_en;
	logic hi_en;
	logic cap_evt;

	// Divider outputs are enables in the system clock domain, never clocks.
	assign tick12   = (state_q.pre12 == `SART_DIV12_LAST);
	assign ext_tick = ext_rise & (state_q.ext_div == `SART_DIV8_LAST);
	assign rtc_tick = rtc_rise & (state_q.rtc_div == `SART_DIV8_LAST);

	// Source bit zero counts the oscillator, one counts the real-time clock.
	assign alt_tick = state_q.ctrl.alt_sel ?
		(state_q.ctrl.cap_src ? rtc_tick : ext_tick) : tick12;

	// Each byte picks system clock or the one shared alternate clock.
	assign lo_en = low_byte_clock_mode_i  ? 1'b1 : alt_tick;
	assign hi_en = high_byte_clock_mode_i ? 1'b1 : alt_tick;

	// Source bit zero captures on the real-time clock, one on the oscillator.
	assign cap_evt = state_q.ctrl.cap_en &
		(state_q.ctrl.cap_src ? ext_tick : rtc_tick);

	// Next state: prescalers, counting, capture, then software writes.
	always_comb begin
		logic        hi_set;
		logic        lo_set;
		logic [15:0] word;
		logic        wr_ctrl;
		hi_set  = 1'b0;
		lo_set  = 1'b0;
		word    = {state_q.cnt_hi, state_q.cnt_lo};
		wr_ctrl = sfr_req_i.wr && (sfr_req_i.addr == `SART_ADDR_CTRL);
		state_d = state_q;

		// Free-running divide by 12.
		if (tick12) begin
			state_d.pre12 = `SART_DIV12_ZERO;
		end else begin
			state_d.pre12 = state_q.pre12 + `SART_DIV12_STEP;
		end

		// Divide by 8 on synchronised rising edges; the counter wraps by itself.
		if (ext_rise) begin
			state_d.ext_div = state_q.ext_div + `SART_DIV8_STEP;
		end
		if (rtc_rise) begin
			state_d.rtc_div = state_q.rtc_div + `SART_DIV8_STEP;
		end

		if (!state_q.ctrl.split) begin
			// One 16-bit timer clocked by the low byte selection and gated by run.
			if (state_q.ctrl.run && lo_en) begin
				if (word == `SART_WORD_MAX) begin
					state_d.cnt_lo = state_q.rl_lo;
					state_d.cnt_hi = state_q.rl_hi;
					hi_set = 1'b1;
					lo_set = 1'b1;
				end else begin
					word = word + `SART_WORD_STEP;
					state_d.cnt_lo = word[7:0];
					state_d.cnt_hi = word[15:8];
					lo_set = (state_q.cnt_lo == `SART_BYTE_MAX);
				end
			end
		end else begin
			// Low byte always runs in split mode; only its clock selection gates it.
			if (lo_en) begin
				if (state_q.cnt_lo == `SART_BYTE_MAX) begin
					state_d.cnt_lo = state_q.rl_lo;
					lo_set = 1'b1;
				end else begin
					state_d.cnt_lo = state_q.cnt_lo + `SART_BYTE_STEP;
				end
			end
			// High byte obeys the run bit and its own clock selection.
			if (state_q.ctrl.run && hi_en) begin
				if (state_q.cnt_hi == `SART_BYTE_MAX) begin
					state_d.cnt_hi = state_q.rl_hi;
					hi_set = 1'b1;
				end else begin
					state_d.cnt_hi = state_q.cnt_hi + `SART_BYTE_STEP;
				end
			end
		end

		// Capture takes the count as it stood before this edge.
		if (cap_evt) begin
			state_d.rl_lo = state_q.cnt_lo;
			state_d.rl_hi = state_q.cnt_hi;
			hi_set = 1'b1;
		end

		// Software writes; a data write beats counting in the same cycle.
		if (sfr_req_i.wr) begin
			case (sfr_req_i.addr)
				`SART_ADDR_RL_LO: begin
					state_d.rl_lo = sfr_req_i.wdata;
				end
				`SART_ADDR_RL_HI: begin
					state_d.rl_hi = sfr_req_i.wdata;
				end
				`SART_ADDR_CNT_LO: begin
					state_d.cnt_lo = sfr_req_i.wdata;
				end
				`SART_ADDR_CNT_HI: begin
					state_d.cnt_hi = sfr_req_i.wdata;
				end
				`SART_ADDR_CTRL: begin
					state_d.ctrl = sfr_req_i.wdata;
				end
				default: begin
				end
			endcase
		end

		// Flags only ever clear by a write; a set in the same cycle still wins.
		state_d.ctrl.hi_flag = (wr_ctrl ? sfr_req_i.wdata[7] : state_q.ctrl.hi_flag) | hi_set;
		state_d.ctrl.lo_flag = (wr_ctrl ? sfr_req_i.wdata[6] : state_q.ctrl.lo_flag) | lo_set;

		// Read data is registered, so it reflects the address one cycle later.
		case (sfr_req_i.addr)
			`SART_ADDR_CTRL: begin
				state_d.rdata = state_q.ctrl;
			end
			`SART_ADDR_RL_LO: begin
				state_d.rdata = state_q.rl_lo;
			end
			`SART_ADDR_RL_HI: begin
				state_d.rdata = state_q.rl_hi;
			end
			`SART_ADDR_CNT_LO: begin
				state_d.rdata = state_q.cnt_lo;
			end
			`SART_ADDR_CNT_HI: begin
				state_d.rdata = state_q.cnt_hi;
			end
			default: begin
				state_d.rdata = `SART_RESET_BYTE;
			end
		endcase
	end

	// State register; everything resets to zero.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign sfr_rdata_o = state_q.rdata;

	// The low flag only reaches the request line when its own enable is set.
	assign irq_o = irq_enable_i &
		(state_q.ctrl.hi_flag | (state_q.ctrl.lo_irq_en & state_q.ctrl.lo_flag));

endmodule : sart_timer
`default_nettype wire

// ---- logic/sart_params.svh ----
// Constants for the split auto-reload timer: addresses, reset values and divider counts.
// Summary of operation
// - High overflow flag sets when high byte wraps; in 16-bit mode on 0xFFFF wrap.
// - Low overflow flag sets on every low byte 0xFF to 0x00 rollover, any mode.
// - With timer interrupt enabled, every high overflow raises the interrupt request.
// - With low interrupt enable bit also set, low or high overflow requests interrupt.
// - Hardware never clears either overflow flag; only a software write clears them.
// - Split bit zero gives one 16-bit timer, one gives two 8-bit timers.
// - Run bit gates whole counter in 16-bit mode, only high byte in split.
// - Capture enable bit turns capture mode off at zero, on at one.
// - Capture source zero captures every 8 RTC cycles, one every 8 oscillator cycles.
// - With alternate select one and low mode zero, source bit also picks count clock.
// - Alternate select zero means system clock over 12, one the chosen divided source.
// - In split mode one alternate clock serves both bytes, each picks independently.
// - Reload low and high bytes sit at 0x92 and 0x93, readable and writable.
// - Count low and high bytes sit at 0x94 and 0x95.
// - In 16-bit mode the wrap from 0xFFFF loads the 16-bit reload value.
// - In split mode each byte reloads from its own reload byte on overflow.
// - Byte clock mode one selects system clock, zero the alternate clock.
// - The divided oscillator source is synchronised to the system clock before use.
`ifndef SART_PARAMS_SVH
`define SART_PARAMS_SVH

`define SART_ADDR_CTRL    8'h91
`define SART_ADDR_RL_LO   8'h92
`define SART_ADDR_RL_HI   8'h93
`define SART_ADDR_CNT_LO  8'h94
`define SART_ADDR_CNT_HI  8'h95

`define SART_RESET_BYTE   8'h00
`define SART_BYTE_MAX     8'hff
`define SART_BYTE_STEP    8'h01
`define SART_WORD_MAX     16'hffff
`define SART_WORD_STEP    16'h0001

`define SART_DIV12_ZERO   4'h0
`define SART_DIV12_LAST   4'hb
`define SART_DIV12_STEP   4'h1
`define SART_DIV8_ZERO    3'h0
`define SART_DIV8_LAST    3'h7
`define SART_DIV8_STEP    3'h1

`endif

// ---- logic/sart_pkg.sv ----
// Types shared by the split auto-reload timer modules.
`default_nettype none
package sart_pkg;

	// Control byte, most significant bit first.
	typedef struct packed {
		logic hi_flag;
		logic lo_flag;
		logic lo_irq_en;
		logic cap_en;
		logic split;
		logic run;
		logic cap_src;
		logic alt_sel;
	} sart_ctrl_t;

	// One special function register access from the core.
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sart_sfr_req_t;

	// Whole state of the timer.
	typedef struct packed {
		sart_ctrl_t ctrl;
		logic [7:0] rl_lo;
		logic [7:0] rl_hi;
		logic [7:0] cnt_lo;
		logic [7:0] cnt_hi;
		logic [3:0] pre12;
		logic [2:0] ext_div;
		logic [2:0] rtc_div;
		logic [7:0] rdata;
	} sart_state_t;

	// Whole state of one pin synchroniser.
	typedef struct packed {
		logic [2:0] sh;
		logic       level;
		logic       rise;
	} sart_sync_state_t;

endpackage : sart_pkg
`default_nettype wire

// ---- logic/sart_sync.sv ----
// Three-stage pin synchroniser with agreement filter and rising edge pulse.
`timescale 1ns/1ps
`default_nettype none
module sart_sync (
	// Clock and reset.
	input  wire logic clock_i,
	input  wire logic rst_b_i,
	// Asynchronous pin and its synchronised view.
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o
);

	sart_pkg::sart_sync_state_t state_q;
	sart_pkg::sart_sync_state_t state_d;

	// The first stage only feeds the second; the filter looks at stages two and three.
	always_comb begin
		state_d = state_q;
		state_d.sh = {state_q.sh[1:0], pin_i};
		if (state_q.sh[1] == state_q.sh[2]) begin
			state_d.level = state_q.sh[2];
		end
		state_d.rise = state_d.level & ~state_q.level;
	end

	// Registers; all stages clear to low.
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign level_o = state_q.level;
	assign rise_o  = state_q.rise;

endmodule : sart_sync
`default_nettype wire

// ---- tb/sart_checker.sv ----
// Port checks for the split auto-reload timer.
`timescale 1ns/1ps
`default_nettype none
module sart_checker (
	// Clock and reset.
	input wire logic                    clock_i,
	input wire logic                    rst_b_i,
	// Register bus.
	input wire sart_pkg::sart_sfr_req_t sfr_req_i,
	input wire logic [7:0]              sfr_rdata_o,
	// Interrupt.
	input wire logic                    irq_enable_i,
	input wire logic                    irq_o
);
	logic [7:0] ctl_q;
	logic       wc;
	// Shadow of the control byte, so reads are only checked while counting cannot move them.
	assign wc = sfr_req_i.wr && sfr_req_i.addr == 8'h91;
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) ctl_q <= 8'h00;
		else if (wc) ctl_q <= sfr_req_i.wdata;
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	irq_gate_a: assert property (!irq_enable_i |-> !irq_o) else $error("irq without enable");
	lo_irq_a: assert property (wc && sfr_req_i.wdata[6:5] == 2'b11 ##1 irq_enable_i |-> irq_o)
		else $error("low flag irq missing");
	lo_mask_a: assert property (wc && sfr_req_i.wdata[7:2] == 6'h10 ##1 irq_enable_i |-> !irq_o)
		else $error("masked low flag raised irq");
	flag_hold_a: assert property (irq_o && !wc ##1 irq_enable_i |-> irq_o)
		else $error("flag dropped by itself");
	stop_quiet_a: assert property (wc && sfr_req_i.wdata == 8'h00 ##1 !sfr_req_i.wr [*3] |-> !irq_o)
		else $error("stopped timer raised a flag");
	rl_back_a: assert property (sfr_req_i.wr && sfr_req_i.addr inside {8'h92, 8'h93} && !ctl_q[4]
		##1 !sfr_req_i.wr && $stable(sfr_req_i.addr) |=> sfr_rdata_o == $past(sfr_req_i.wdata, 2))
		else $error("reload byte read back wrong");
	cnt_back_a: assert property (sfr_req_i.wr && sfr_req_i.addr == 8'h95 && ctl_q[3:2] == 2'b00
		##1 !sfr_req_i.wr && sfr_req_i.addr == 8'h95 |=> sfr_rdata_o == $past(sfr_req_i.wdata, 2))
		else $error("stopped count read back wrong");
	unmapped_a: assert property (!(sfr_req_i.addr inside {[8'h91:8'h95]}) |=> sfr_rdata_o == 8'h00)
		else $error("unmapped read not zero");
endmodule : sart_checker
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the split auto-reload timer.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                    clock_i = 1'b0;
	logic                    rst_b_i = 1'b0;
	sart_pkg::sart_sfr_req_t req     = '0;
	logic [7:0]              rdata;
	logic                    lm = 1'b1, hm = 1'b1, ext = 1'b0, rtc = 1'b0, ie = 1'b1;
	logic                    irq, rd_tag = 1'b0, pend = 1'b0;
	logic [7:0]              exp_q[$];
	int                      err_total = 0, checks = 0;
	// 40 MHz system clock.
	always #12.5 clock_i = ~clock_i;
	sart_timer DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
		.low_byte_clock_mode_i(lm), .high_byte_clock_mode_i(hm), .ext_osc_i(ext),
		.rtc_clk_i(rtc), .irq_enable_i(ie), .irq_o(irq));
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks++;
		if (seen !== want) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	// Read data lags the address by one edge, so the note is taken at the following falling edge.
	always @(posedge clock_i) pend <= rd_tag;
	always @(negedge clock_i) if (pend) check(rdata, exp_q.pop_front());
	task automatic drive(input logic w, input logic [7:0] a, input logic [7:0] d, input logic r);
		@(negedge clock_i);
		req <= '{w, a, d};
		rd_tag <= r;
	endtask : drive
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		drive(1'b1, a, d, 1'b0);
		drive(1'b0, a, 8'h00, 1'b0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		drive(1'b0, a, 8'h00, 1'b1);
		drive(1'b0, a, 8'h00, 1'b0);
	endtask : rd
	// Slow pins toggle with a random half period; the clocks stand still otherwise.
	task automatic pins(input bit use_rtc, input int n);
		repeat (2 * n) begin
			@(negedge clock_i);
			if (use_rtc) rtc <= ~rtc;
			else ext <= ~ext;
			repeat ($urandom_range(2, 5)) @(negedge clock_i);
		end
	endtask : pins
	task automatic wait_irq();
		int k;
		k = 0;
		while (irq !== 1'b1 && k < 2000) begin
			@(negedge clock_i);
			k++;
		end
		if (k == 2000) begin
			err_total++;
			$display("MISMATCH t=%0t irq wait timed out", $time);
			close_out();
		end
	endtask : wait_irq
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	// Main sequence.
	initial begin
		logic [7:0] v;
		void'($urandom(34988));
		repeat (3) @(negedge clock_i);
		rst_b_i <= 1'b1;
		for (int a = 8'h90; a <= 8'h96; a++) rd(8'(a), 8'h00);
		wr(8'h91, 8'h40);
		check({7'h00, irq}, 8'h00);
		wr(8'h91, 8'h60);
		check({7'h00, irq}, 8'h01);
		ie <= 1'b0;
		@(negedge clock_i);
		check({7'h00, irq}, 8'h00);
		ie <= 1'b1;
		wr(8'h91, 8'h00);
		repeat (3) @(negedge clock_i);
		check({7'h00, irq}, 8'h00);
		$display("test reset and flags done");
		for (int a = 8'h92; a <= 8'h95; a++) begin
			v = 8'($urandom);
			wr(8'(a), v);
			rd(8'(a), v);
		end
		$display("test register access done");
		wr(8'h92, 8'h34);
		wr(8'h93, 8'h12);
		wr(8'h94, 8'hfe);
		wr(8'h95, 8'hff);
		wr(8'h91, 8'h04);
		wait_irq();
		wr(8'h91, 8'hc0);
		rd(8'h95, 8'h12);
		repeat (10) @(negedge clock_i);
		rd(8'h91, 8'hc0);
		$display("test wide wrap done");
		wr(8'h92, 8'hf0);
		wr(8'h93, 8'haa);
		wr(8'h95, 8'h77);
		wr(8'h94, 8'hfd);
		wr(8'h91, 8'h28);
		wait_irq();
		rd(8'h91, 8'h68);
		rd(8'h95, 8'h77);
		wr(8'h91, 8'h0c);
		wait_irq();
		wr(8'h91, 8'h08);
		rd(8'h95, 8'hac);
		$display("test split done");
		lm <= 1'b0;
		wr(8'h91, 8'h09);
		wr(8'h94, 8'h00);
		pins(1'b0, 16);
		repeat (8) @(negedge clock_i);
		rd(8'h94, 8'h02);
		$display("test divided source done");
		// The divide-by-12 phase is free running, so one tick either way is allowed.
		wr(8'h91, 8'h08);
		wr(8'h94, 8'h00);
		repeat (120) @(negedge clock_i);
		check(8'(rdata inside {8'h09, 8'h0a, 8'h0b}), 8'h01);
		$display("test divide by twelve done");
		lm <= 1'b1;
		wr(8'h93, 8'h55);
		wr(8'h95, 8'h00);
		wr(8'h94, 8'h00);
		wr(8'h91, 8'h14);
		pins(1'b1, 8);
		repeat (8) @(negedge clock_i);
		rd(8'h93, 8'h00);
		rd(8'h91, 8'h94);
		$display("test capture done");
		close_out();
	end
endmodule : tb
bind sart_timer sart_checker u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i), .sfr_req_i(sfr_req_i),
	.sfr_rdata_o(sfr_rdata_o), .irq_enable_i(irq_enable_i), .irq_o(irq_o));
`default_nettype wire
